// ---- logic/asc_ctrl.sv ----
// anti-shock dram refresh, mode switch, gain ramp, mute and compare control
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module asc_ctrl
  import asc_pkg::*;
#(
  parameter int FIRST_WR_CYCLES = FIRST_WR_CYC
) (
  input  wire logic        clk_sys,              // 20 mhz system clock
  input  wire logic        rst_n,                // async reset, active low
  input  wire logic        psel,                 // apb select
  input  wire logic        penable,              // apb enable
  input  wire logic        pwrite,               // apb direction
  input  wire logic [3:0]  paddr,                // apb byte address
  input  wire logic [31:0] pwdata,               // apb write data
  output logic      [31:0] prdata,               // apb read data
  output logic             pready,               // apb ready
  output logic             pslverr,              // apb error, unmapped address
  input  wire logic        input_word_clock,     // word clock pin, fs
  input  wire logic        external_silence_pin, // mute pin, active high
  input  wire logic        valid_data_empty,     // no valid data in dram
  input  wire logic        block_boundary,       // one-cycle pulse at block end
  input  wire logic        sample_valid,         // input sample strobe
  input  wire logic        sample_left,          // strobed sample is left channel
  input  wire logic [15:0] sample_in,            // signed input sample
  input  wire logic [15:0] cmp_stored,           // valid data for compare
  input  wire logic [15:0] cmp_fresh,            // re-read data for compare
  output logic      [15:0] sample_out,           // gained, muted sample
  output logic             sample_out_valid,     // output strobe
  output logic             refresh_pulse,        // ras-only refresh cycle
  output logic             first_write,          // first encode write go
  output logic             decode_read,          // decode read strobe
  output logic             encode_active_flag,   // encode sequence running
  output logic             decode_active_flag,   // decode sequence running
  output logic      [1:0]  compression_mode,     // mode now in force
  output logic             compare_match         // compare result
);

  // the first-write delay counter is sixteen bits wide
  if (FIRST_WR_CYCLES < 1 || FIRST_WR_CYCLES > 65535) begin : g_bad_delay
    $error("FIRST_WR_CYCLES out of range");
  end

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [7:0]        gain_apply_flag;
    logic [1:0]        mode;
    logic              pend;
    logic              zero_blk;
    logic [3:0]        init_cnt;
    logic [15:0]       wr_dly;
    logic              wr_wait;
    logic [8:0]        gain;
    logic [1:0]        div;
    logic              mute;
    logic              jf_armed;
    logic              jf_run;
    logic              prev_son;
    logic              prev_wr;
    logic              prev_soft;
    logic [2:0]        wclk_s;
    logic [1:0]        sil_s;
    logic [1:0]        emp_s;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              refresh;
    logic              first_wr;
    logic              dec_rd;
    logic              enc_act;
    logic              dec_act;
    logic [15:0]       dout;
    logic              dvalid;
    logic              cmp_match;
    logic [4:0]        ref_run;
  } state_t;

  state_t q, d;

  logic              son, fs_tick, step_tick, soft_fall, mute_now;
  logic [8:0]        tgt;
  logic signed [25:0] prod;

  function automatic logic mapped(input logic [3:0] a);
    mapped = (a == ADDR_CTRL) || (a == ADDR_ATT) || (a == ADDR_STAT);
  endfunction

  always_comb begin
    d = q;
    son = q.ctrl[B_SON];
    // the first flop of each synchroniser feeds only the second
    d.wclk_s = {q.wclk_s[1:0], input_word_clock};
    d.sil_s  = {q.sil_s[0], external_silence_pin};
    d.emp_s  = {q.emp_s[0], valid_data_empty};
    fs_tick  = q.wclk_s[1] && !q.wclk_s[2];
    step_tick = fs_tick && (q.div == FS_PER_STEP_M1);
    soft_fall = q.prev_soft && !q.ctrl[B_SOFT];
    tgt = q.ctrl[B_APPLY] ? {1'b0, q.gain_apply_flag} : GAIN_UNITY;

    // deferred compression mode switch, followed by a zero block; it sits
    // ahead of the bus write so a mode written on a boundary cycle is kept
    if (!son) begin
      d.mode = q.ctrl[B_MODE +: 2];
      d.pend = 1'b0;
      d.zero_blk = 1'b0;
    end else if (block_boundary) begin
      d.zero_blk = q.pend;
      if (q.pend) begin
        d.mode = q.ctrl[B_MODE +: 2];
        d.pend = 1'b0;
      end
    end

    // apb: one wait state, write lands at the edge that samples pready
    d.pready = 1'b0;
    if (psel && penable && !q.pready) begin
      d.pready  = 1'b1;
      d.pslverr = !mapped(paddr);
      d.prdata  = 32'h0000_0000;
      if (!pwrite) begin
        unique case (paddr)
          ADDR_CTRL: d.prdata[CTRL_W-1:0] = q.ctrl;
          ADDR_ATT:  d.prdata[7:0] = q.gain_apply_flag;
          ADDR_STAT: begin
            d.prdata[S_GAIN +: 9] = q.gain;
            d.prdata[S_INIT] = (q.init_cnt != 4'h0);
            d.prdata[S_ENC]  = q.enc_act;
            d.prdata[S_DEC]  = q.dec_act;
            d.prdata[S_MUTE] = q.mute;
            d.prdata[S_ZERO] = q.zero_blk;
            d.prdata[S_PEND] = q.pend;
            d.prdata[S_JF]   = q.jf_run;
            d.prdata[S_MODE +: 2] = q.mode;
          end
          default: d.prdata = 32'h0000_0000;
        endcase
      end
    end
    if (psel && penable && q.pready && pwrite) begin
      if (paddr == ADDR_CTRL) begin
        d.ctrl = pwdata[CTRL_W-1:0];
        // mode write in shock-proof waits for a block boundary
        if (pwdata[B_MODE +: 2] != q.mode) begin
          d.pend = pwdata[B_SON];
        end
      end
      if (paddr == ADDR_ATT) begin
        d.gain_apply_flag = pwdata[7:0];
      end
    end
    d.prev_son  = son;
    d.prev_wr   = q.ctrl[B_WREN];
    d.prev_soft = q.ctrl[B_SOFT];

    // initialization refresh: the only dedicated refresh cycles
    d.refresh = son && (q.init_cnt != 4'h0);
    d.ref_run = q.refresh ? q.ref_run + 5'h01 : 5'h00;
    if (q.init_cnt != 4'h0) begin
      d.init_cnt = q.init_cnt - 4'h1;
    end
    if (son && !q.prev_son) begin
      d.init_cnt = INIT_REFRESH_N;
    end
    d.first_wr = 1'b0;
    if (son && q.prev_son && !q.ctrl[B_RDEN] && !q.prev_wr && q.ctrl[B_WREN]) begin
      d.init_cnt = INIT_REFRESH_N;
      d.wr_wait  = 1'b1;
      d.wr_dly   = 16'(FIRST_WR_CYCLES - 1);
    end else if (q.wr_wait) begin
      d.wr_dly = q.wr_dly - 16'h0001;
      if (q.wr_dly == 16'h0000) begin
        d.wr_wait  = 1'b0;
        d.first_wr = son && q.ctrl[B_WREN];
      end
    end
    // only leaving shock-proof cuts the refresh run short; dropping write
    // enable merely abandons a first write still waiting
    if (!son) begin
      d.init_cnt = 4'h0;
      d.wr_wait  = 1'b0;
    end else if (!q.ctrl[B_WREN]) begin
      d.wr_wait = 1'b0;
    end

    // access activity; dram reads are the refresh, paced by fs
    d.enc_act = son && q.ctrl[B_WREN];
    d.dec_act = son && q.ctrl[B_RDEN] && !q.emp_s[1];
    d.dec_rd  = d.dec_act && fs_tick;

    // through-mode jitter-free timing restarts after enable falls
    if (q.prev_son && !son) begin
      d.jf_armed = 1'b1;
      d.jf_run   = 1'b0;
    end else if (q.jf_armed && fs_tick) begin
      d.jf_armed = 1'b0;
      d.jf_run   = 1'b1;
    end

    // gain ramp, soft mute and release jump
    if (fs_tick) begin
      d.div = q.div + 2'h1;
    end
    if (soft_fall) begin
      d.gain = tgt;
    end else if (step_tick) begin
      if (q.ctrl[B_SOFT]) begin
        if (q.gain != 9'h000) begin
          d.gain = q.gain - 9'h001;
        end
      end else if (q.gain < tgt) begin
        d.gain = q.gain + 9'h001;
      end else if (q.gain > tgt) begin
        d.gain = q.gain - 9'h001;
      end
    end

    // mute is only re-evaluated at a left word so l/r stay paired
    mute_now = q.mute;
    if (sample_valid && sample_left) begin
      mute_now = q.sil_s[1] || q.ctrl[B_FMUTE] || (son && q.emp_s[1]);
    end
    d.mute = mute_now;
    prod = $signed(sample_in) * $signed({1'b0, q.gain});
    d.dvalid = sample_valid && (son || q.jf_run);
    if (sample_valid) begin
      d.dout = (mute_now || q.zero_blk) ? 16'h0000 : prod[23:8];
    end

    // compare drops the low nibble when the flag is set
    d.cmp_match = q.ctrl[B_UPPER_BITS_COMPARE_FLAG] ? (cmp_stored[15:4] == cmp_fresh[15:4])
                                  : (cmp_stored == cmp_fresh);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.ctrl <= CTRL_RST;
      q.gain_apply_flag  <= ATT_RST;
      q.gain <= GAIN_UNITY;
      q.jf_armed <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign prdata             = q.prdata;
  assign pready             = q.pready;
  assign pslverr            = q.pslverr;
  assign sample_out         = q.dout;
  assign sample_out_valid   = q.dvalid;
  assign refresh_pulse      = q.refresh;
  assign first_write        = q.first_wr;
  assign decode_read        = q.dec_rd;
  assign encode_active_flag = q.enc_act;
  assign decode_active_flag = q.dec_act;
  assign compression_mode   = q.mode;
  assign compare_match      = q.cmp_match;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_init_load: assert property (son && !q.prev_son |=> q.init_cnt == 4'hF)
    else $error("init refresh not loaded");
  a_refresh_init: assert property (q.refresh |-> $past(q.init_cnt) != 4'h0)
    else $error("refresh outside init");
  a_off_quiet: assert property (!son [*2] |-> !q.refresh && !q.dec_rd && !q.first_wr)
    else $error("dram access while off");
  a_dec_gate: assert property (q.dec_rd |-> $past(son) && $past(q.ctrl[B_RDEN])
                               && !$past(q.emp_s[1]))
    else $error("decode read without data");
  a_mode_defer: assert property (son && $changed(q.mode) |-> $past(block_boundary))
    else $error("mode changed off boundary");
  a_soft_jump: assert property (soft_fall |=> q.gain == $past(tgt))
    else $error("no jump on soft release");
  a_gain_rate: assert property (!step_tick && !soft_fall |=> $stable(q.gain))
    else $error("gain moved between steps");
  a_mute_left: assert property ($changed(q.mute) |-> $past(sample_valid)
                                && $past(sample_left))
    else $error("mute changed mid pair");
  a_auto_mute: assert property (son && q.emp_s[1] && sample_valid && sample_left
                                |=> q.mute && q.dout == 16'h0000)
    else $error("empty data not muted");
  a_cmp_upper: assert property (q.ctrl[B_UPPER_BITS_COMPARE_FLAG] && cmp_stored[15:4] == cmp_fresh[15:4]
                                |=> q.cmp_match)
    else $error("upper compare failed");

  // further guards on refresh length, first write, decode pace, zero block, through mode, attenuation hold, ramp and mute
  a_init_count: assert property (son && $fell(q.refresh) |-> q.ref_run == 5'h0F)
    else $error("init refresh run not fifteen");
  a_first_son: assert property (q.first_wr |-> $past(son) && $past(q.ctrl[B_WREN]))
    else $error("first write without encode");
  a_dec_pace: assert property (q.dec_rd |-> $past(fs_tick))
    else $error("decode read off the sample pace");
  a_zero_out: assert property (son && q.zero_blk && sample_valid |=> q.dout == 16'h0000)
    else $error("zero block not silent");
  a_through_idle: assert property (!son |=> !q.enc_act && !q.dec_act)
    else $error("sequence active in through mode");
  a_att_hold: assert property (!pwrite |=> $stable(q.gain_apply_flag))
    else $error("attenuation changed without write");
  a_unity_gain: assert property (!q.ctrl[B_APPLY] && !q.ctrl[B_SOFT]
                                 && q.gain == GAIN_UNITY |=> q.gain == GAIN_UNITY)
    else $error("unity gain not held");
  a_ramp_move: assert property (step_tick && !q.ctrl[B_SOFT] && q.gain != tgt
                                && !soft_fall |=> q.gain != $past(q.gain))
    else $error("gain ramp stalled");
  a_soft_step: assert property (step_tick && q.ctrl[B_SOFT] && q.gain != 9'h000
                                && !soft_fall |=> q.gain == $past(q.gain) - 9'h001)
    else $error("soft mute step wrong");
  a_force_mute: assert property (q.ctrl[B_FMUTE] && sample_valid && sample_left
                                 |=> q.mute)
    else $error("forced mute ignored");
  a_pin_mute: assert property (q.sil_s[1] && sample_valid && sample_left
                               |=> q.dout == 16'h0000)
    else $error("mute pin ignored");

  c_init_run: cover property (son && !q.prev_son ##[1:20] q.init_cnt == 4'h0);
  c_soft_mute: cover property (q.ctrl[B_SOFT] && q.gain == 9'h000);
  c_mode_switch: cover property (q.pend ##[1:1000] q.zero_blk);
  // first write and through-mode restart are the rarer paths
  c_first_write: cover property (q.first_wr);
  c_through_restart: cover property (q.jf_armed ##[1:40] q.jf_run);

endmodule // asc_ctrl

// ---- logic/asc_pkg.sv ----
// constants for the anti-shock refresh, gain and mute control block
package asc_pkg;
  // apb register byte offsets
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_ATT  = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;
  // control register fields
  localparam int B_SON   = 0;
  localparam int B_RDEN  = 1;
  localparam int B_WREN  = 2;
  localparam int B_APPLY = 3;
  localparam int B_SOFT  = 4;
  localparam int B_FMUTE = 5;
  localparam int B_UPPER_BITS_COMPARE_FLAG = 6;
  localparam int B_MODE  = 8;
  localparam int CTRL_W  = 10;
  // status register fields
  localparam int S_GAIN  = 0;
  localparam int S_INIT  = 9;
  localparam int S_ENC   = 10;
  localparam int S_DEC   = 11;
  localparam int S_MUTE  = 12;
  localparam int S_ZERO  = 13;
  localparam int S_PEND  = 14;
  localparam int S_JF    = 15;
  localparam int S_MODE  = 16;
  // reset values and figures
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
  localparam logic [7:0]  ATT_RST    = 8'h40;
  localparam logic [8:0]  GAIN_UNITY = 9'h100;
  localparam logic [3:0]  INIT_REFRESH_N = 4'hF;
  localparam logic [1:0]  FS_PER_STEP_M1 = 2'h3;
  localparam int    CLK_HZ      = 20_000_000;
  localparam real   FIRST_WR_MS = 0.7;
  localparam int    FIRST_WR_CYC = int'($ceil(FIRST_WR_MS * CLK_HZ / 1000.0));
endpackage

// ---- tb/audio_source.sv ----
// behavioural serial-audio source standing in for the disc signal processor
`timescale 1ns/1ps
module audio_source (
  input  wire logic        clk_sys,    // system clock
  input  wire logic        rst_n,      // reset, active low
  input  wire logic [15:0] next_word,  // data for the next strobe
  output logic             word_clock, // fs word clock
  output logic             strobe,     // one-cycle sample strobe
  output logic             left,       // strobe carries left channel
  output logic      [15:0] word        // sample data
);
  logic [1:0] sync_q;
  initial begin
    word_clock = 1'b0;
    #37;
    forever #200 word_clock = ~word_clock; // free-running fs, phase unrelated
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync_q <= 2'h0;
      strobe <= 1'b0;
      left   <= 1'b0;
      word   <= 16'h0000;
    end else begin
      sync_q <= {sync_q[0], word_clock};
      strobe <= sync_q[0] ^ sync_q[1];
      left   <= sync_q[0];
      // data churns between strobes so a late capture cannot pass by luck
      word   <= (sync_q[0] ^ sync_q[1]) ? next_word : ~word;
    end
  end
endmodule // audio_source

// ---- tb/tb.sv ----
// self-checking bench for the anti-shock gain, mute and refresh control
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; $display("[ERR] %0t %h %h", $time, a, b); end end
module tb;
  import asc_pkg::*;
  localparam int FW = 20;
  logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, e, chk, mx;
  logic        ext_mute, empty, blk, sv, sl, sov, rf, fw, dr, ea, da, cm, wc;
  logic [3:0]  paddr;
  logic [31:0] pwdata, prdata, r, seed;
  logic [15:0] si, so, cs, cf, ew;
  logic [1:0]  mode;
  int          bad_count, n_tests, cyc, nref, nfw, ndr, nout, gx, t, tfw;

  asc_ctrl #(.FIRST_WR_CYCLES(FW)) DUT (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .input_word_clock(wc), .external_silence_pin(ext_mute),
    .valid_data_empty(empty), .block_boundary(blk), .sample_valid(sv), .sample_left(sl),
    .sample_in(si), .cmp_stored(cs), .cmp_fresh(cf), .sample_out(so), .sample_out_valid(sov),
    .refresh_pulse(rf), .first_write(fw), .decode_read(dr), .encode_active_flag(ea),
    .decode_active_flag(da), .compression_mode(mode), .compare_match(cm));
  audio_source src (.clk_sys(clk_sys), .rst_n(rst_n), .next_word(seed[15:0]),
    .word_clock(wc), .strobe(sv), .left(sl), .word(si));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [15:0] mdl(input logic [15:0] s);
    int p;
    p = $signed(s) * gx;
    return mx ? 16'h0000 : p[23:8];
  endfunction

  always @(posedge clk_sys) begin
    cyc++;
    if (rf === 1'b1) nref++;
    if (dr === 1'b1) ndr++;
    if (fw === 1'b1) begin
      nfw++;
      tfw = cyc;
    end
    if (sv === 1'b1) begin
      ew <= mdl(si);
      seed <= lfsr(seed);
    end
    if (sov === 1'b1) begin
      nout++;
      if (chk) `CHK(so, ew)
    end
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // the leading edge keeps a release and the next setup out of one time step
  task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (pready !== 1'b1 && i < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 20) begin
      bad_count++;
      give_verdict();
    end
  endtask
  task automatic poll(input logic [8:0] g);
    int i;
    i = 0;
    do begin
      apb(1'b0, ADDR_STAT, 32'h0);
      i++;
    end while (r[8:0] !== g && i < 3000);
    if (i >= 3000) begin
      bad_count++;
      give_verdict();
    end
  endtask
  // output checks only run well clear of a change, since mute switches per pair
  task automatic settle(input logic m, input int g);
    chk = 1'b0;
    mx = m;
    gx = g;
    tick(60);
    chk = 1'b1;
    tick(80);
    chk = 1'b0;
  endtask
  task automatic boundary;
    blk <= 1'b1;
    tick(1);
    blk <= 1'b0;
    tick(3);
  endtask

  initial begin
    {rst_n, psel, penable, pwrite, ext_mute, empty, blk, chk, mx} = 9'h000;
    paddr = 4'h0;
    pwdata = 32'h0;
    cs = 16'h0000;
    cf = 16'h0000;
    seed = 32'h86A89C09;
    gx = 256;
    tick(4);
    rst_n <= 1'b1;
    apb(1'b0, ADDR_ATT, 32'h0);
    `CHK(r[7:0], ATT_RST)
    apb(1'b0, ADDR_CTRL, 32'h0);
    `CHK(r[B_APPLY], 1'b0)
    apb(1'b0, ADDR_STAT, 32'h0);
    `CHK(r[8:0], GAIN_UNITY)
    apb(1'b0, 4'hC, 32'h0);
    `CHK(e, 1'b1)
    settle(1'b0, 256);
    `CHK(nref, 0)
    `CHK(nout > 20, 1'b1)
    apb(1'b1, ADDR_ATT, 32'h80);
    tick(100);
    apb(1'b0, ADDR_STAT, 32'h0);
    `CHK(r[8:0], 9'h100)
    t = cyc;
    apb(1'b1, ADDR_CTRL, 32'h8);
    tick(1000);
    apb(1'b1, ADDR_ATT, 32'h60);
    poll(9'h060);
    `CHK((cyc - t) inside {[5050:5250]}, 1'b1)
    settle(1'b0, 96);
    t = cyc;
    apb(1'b1, ADDR_CTRL, 32'h18);
    poll(9'h000);
    `CHK((cyc - t) inside {[3000:3200]}, 1'b1)
    apb(1'b1, ADDR_CTRL, 32'h8);
    tick(8);
    apb(1'b0, ADDR_STAT, 32'h0);
    `CHK(r[8:0], 9'h060)
    for (int k = 0; k < 2; k++) begin
      if (k == 0) apb(1'b1, ADDR_CTRL, 32'h28);
      else ext_mute <= 1'b1;
      settle(1'b1, 96);
      apb(1'b1, ADDR_CTRL, 32'h8);
      ext_mute <= 1'b0;
      settle(1'b0, 96);
    end
    empty <= 1'b1;
    nref = 0;
    apb(1'b1, ADDR_CTRL, 32'h9);
    settle(1'b1, 96);
    `CHK(nref, 15)
    apb(1'b1, ADDR_CTRL, 32'hB);
    tick(20);
    `CHK(da, 1'b0)
    empty <= 1'b0;
    tick(10);
    ndr = 0;
    tick(40);
    `CHK(da, 1'b1)
    `CHK(ndr inside {[4:6]}, 1'b1)
    `CHK(nref, 15)
    apb(1'b1, ADDR_CTRL, 32'h20B);
    tick(10);
    `CHK(mode, 2'h0)
    boundary();
    `CHK(mode, 2'h2)
    apb(1'b0, ADDR_STAT, 32'h0);
    `CHK(r[S_ZERO], 1'b1)
    boundary();
    apb(1'b1, ADDR_CTRL, 32'h209);
    nref = 0;
    nfw = 0;
    t = cyc;
    apb(1'b1, ADDR_CTRL, 32'h20D);
    tick(FW + 60);
    `CHK(nref, 15)
    `CHK(nfw, 1)
    `CHK((tfw - t) inside {[FW:FW + 12]}, 1'b1)
    `CHK(ea, 1'b1)
    apb(1'b1, ADDR_CTRL, 32'h208);
    nref = 0;
    ndr = 0;
    settle(1'b0, 96);
    `CHK(nref + ndr, 0)
    `CHK(ea, 1'b0)
    apb(1'b0, ADDR_STAT, 32'h0);
    `CHK(r[S_JF], 1'b1)
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, ADDR_CTRL, (k == 1) ? 32'h248 : 32'h208);
      cs <= seed[15:0];
      cf <= seed[15:0] ^ 16'h000F;
      tick(3);
      `CHK(cm, k[0])
    end
    give_verdict();
  end
endmodule // tb
